/* File: rtl/pfm_top.sv */
// Pad function multiplexer with AXI4-Lite configuration registers
`timescale 1ns/1ps
module pfm_top
  import pfm_pkg::*;
#(
  parameter int PADS = 8,
  parameter int SHARED_INS = 2
)
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // AXI4-Lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Peripheral output functions, one vector per alternate slot
  input wire logic [PADS-1:0] alt_out [4],
  input wire logic [PADS-1:0] alt_oe [4],
  input wire logic [PADS-1:0] alt_present [4],
  input wire logic [PADS-1:0] nmi_out,
  input wire logic [PADS-1:0] nmi_oe,
  // Pad side
  input wire logic [PADS-1:0] pad_in,
  output logic [PADS-1:0] pad_out,
  output logic [PADS-1:0] pad_oe,
  // Peripheral input side
  output logic [PADS-1:0] periph_in,
  output logic [SHARED_INS-1:0] shared_in,
  input wire logic [PADS-1:0] wkup_restrict,
  input wire logic standby,
  output logic [PADS-1:0] wakeup_in,
  output logic [PADS-1:0] ext_irq_in,
  output logic [PADS-1:0] standby_exit
);

  localparam int IW = $clog2(PADS);

  // Elaboration check: pad vectors and selects must fit one bus word
  if (PADS < 4 || PADS > 32 || SHARED_INS < 1 || IW*SHARED_INS > 32)
  begin : g_param_chk
    $error("pfm_top: unsupported PADS or SHARED_INS");
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  typedef enum {WR_IDLE, WR_RESP} pfm_wr_st_t;
  typedef enum {RD_IDLE, RD_WAIT, RD_LOAD, RD_RESP} pfm_rd_st_t;

  pfm_wr_st_t wst_r, wst_nxt;
  pfm_rd_st_t rst_r, rst_nxt;
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [11:0] awaddr_r, awaddr_nxt, araddr_r, araddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [IW*SHARED_INS-1:0] sel_r, sel_nxt;
  logic [PADS-1:0] gpo_r, gpo_nxt;
  logic awrdy_r, wrdy_r, ardy_r, bv_r, rv_r;
  logic mem_we;
  logic [IW-1:0] mem_ridx;
  logic [4:0] mem_rdata;
  pfm_cfg_t [PADS-1:0] cfg;

  // Address decode helpers
  function automatic logic is_cfg(input logic [11:0] a);
    return a[11:2] < 10'(PADS);
  endfunction

  function automatic logic is_reg(input logic [11:0] a);
    return is_cfg(a) || a == PFM_SEL_ADDR || a == PFM_GPO_ADDR ||
      a == PFM_PIN_ADDR || a == PFM_STBY_ADDR;
  endfunction

  pfm_cfg_mem #(.PADS(PADS)) u_mem (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .wr_en(mem_we),
    .wr_idx(awaddr_r[IW+1:2]),
    .wr_data(wdata_r[4:0]),
    .rd_idx(mem_ridx),
    .rd_data(mem_rdata),
    .cfg_all(cfg)
  );

  // Write channel: address and data in either order
  always_comb
  begin
    wst_nxt = wst_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bresp_nxt = bresp_r;
    sel_nxt = sel_r;
    gpo_nxt = gpo_r;
    mem_we = 1'b0;
    case (wst_r)
      WR_IDLE:
      begin
        // Only a real handshake takes a beat, never a bare valid
        if (s_axi_awvalid && awrdy_r)
        begin
          aw_got_nxt = 1'b1;
          awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wrdy_r)
        begin
          w_got_nxt = 1'b1;
          wdata_nxt = s_axi_wdata;
          wstrb_nxt = s_axi_wstrb;
        end
        if (aw_got_r && w_got_r)
        begin
          bresp_nxt = is_reg(awaddr_r) ? PFM_RESP_OKAY : PFM_RESP_SLVERR;
          // Config word lives in the low byte lane
          mem_we = is_cfg(awaddr_r) && wstrb_r[0];
          if (awaddr_r == PFM_SEL_ADDR && wstrb_r[0])
            sel_nxt = wdata_r[IW*SHARED_INS-1:0];
          if (awaddr_r == PFM_GPO_ADDR && wstrb_r[0])
            gpo_nxt = wdata_r[PADS-1:0];
          aw_got_nxt = 1'b0;
          w_got_nxt = 1'b0;
          wst_nxt = WR_RESP;
        end
      end
      WR_RESP:
        if (s_axi_bready)
          wst_nxt = WR_IDLE;
      default:
        wst_nxt = WR_IDLE;
    endcase
  end

  // Read channel: two wait states, index settles then memory answers
  always_comb
  begin
    rst_nxt = rst_r;
    araddr_nxt = araddr_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    mem_ridx = araddr_r[IW+1:2];
    case (rst_r)
      RD_IDLE:
        if (s_axi_arvalid && ardy_r)
        begin
          araddr_nxt = s_axi_araddr;
          rst_nxt = RD_WAIT;
        end
      RD_WAIT:
        rst_nxt = RD_LOAD;
      RD_LOAD:
      begin
        rresp_nxt = is_reg(araddr_r) ? PFM_RESP_OKAY : PFM_RESP_SLVERR;
        rdata_nxt = 32'h0000_0000;
        if (is_cfg(araddr_r))
          rdata_nxt[4:0] = mem_rdata;
        else if (araddr_r == PFM_SEL_ADDR)
          rdata_nxt[IW*SHARED_INS-1:0] = sel_r;
        else if (araddr_r == PFM_GPO_ADDR)
          rdata_nxt[PADS-1:0] = gpo_r;
        else if (araddr_r == PFM_PIN_ADDR)
          rdata_nxt[PADS-1:0] = pad_in;
        else if (araddr_r == PFM_STBY_ADDR)
          rdata_nxt[PADS-1:0] = standby_exit;
        rst_nxt = RD_RESP;
      end
      RD_RESP:
        if (s_axi_rready)
          rst_nxt = RD_IDLE;
      default:
        rst_nxt = RD_IDLE;
    endcase
  end

  // Bus state registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wst_r <= WR_IDLE;
      rst_r <= RD_IDLE;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 12'h000;
      araddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      rdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bresp_r <= PFM_RESP_OKAY;
      rresp_r <= PFM_RESP_OKAY;
      sel_r <= '0;
      gpo_r <= '0;
    end
    else if (clk_en)
    begin
      wst_r <= wst_nxt;
      rst_r <= rst_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      araddr_r <= araddr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      wstrb_r <= wstrb_nxt;
      bresp_r <= bresp_nxt;
      rresp_r <= rresp_nxt;
      sel_r <= sel_nxt;
      gpo_r <= gpo_nxt;
    end
  end

  // Ready/valid are flops; readies drop once the beat is held
  assign s_axi_awready = awrdy_r;
  assign s_axi_wready = wrdy_r;
  assign s_axi_arready = ardy_r;
  assign s_axi_bvalid = bv_r;
  assign s_axi_rvalid = rv_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // Handshake flags registered from next-state values
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      awrdy_r <= 1'b0;
      wrdy_r <= 1'b0;
      ardy_r <= 1'b0;
      bv_r <= 1'b0;
      rv_r <= 1'b0;
    end
    else if (clk_en)
    begin
      awrdy_r <= wst_nxt == WR_IDLE && !aw_got_nxt && !(aw_got_r && w_got_r);
      wrdy_r <= wst_nxt == WR_IDLE && !w_got_nxt && !(aw_got_r && w_got_r);
      ardy_r <= rst_nxt == RD_IDLE;
      bv_r <= wst_nxt == WR_RESP;
      rv_r <= rst_nxt == RD_RESP;
    end
  end

  // ----------------------------------------
  // Pad muxing
  // ----------------------------------------
  logic [PADS-1:0] pout_nxt, poe_nxt, pin_nxt, wk_nxt, sx_nxt;
  logic [SHARED_INS-1:0] sh_nxt;

  // Output select, input gating and wakeup fan-out
  always_comb
  begin
    for (int p = 0; p < PADS; p++)
    begin
      pfm_alt_t alt;
      alt = pfm_alt_t'(cfg[p].pad_alt_select); // RULE_01
      pout_nxt[p] = 1'b0;
      poe_nxt[p] = 1'b0;
      if (cfg[p].nmi_sel)
      begin
        pout_nxt[p] = nmi_out[p]; // RULE_05
        poe_nxt[p] = nmi_oe[p]; // RULE_05
      end
      else if (alt == PFM_ALT_ZERO)
      begin
        // GPIO: buffer enable steers the driver at once
        pout_nxt[p] = gpo_r[p];
        poe_nxt[p] = cfg[p].output_buffer_enable; // RULE_08
      end
      else if (alt_present[alt][p])
      begin
        // Peripheral owns direction; buffer enable ignored here
        pout_nxt[p] = alt_out[alt][p]; // RULE_07
        poe_nxt[p] = alt_oe[alt][p];
      end
      else
        poe_nxt[p] = 1'b0; // RULE_12
      pin_nxt[p] = pad_in[p] & cfg[p].input_buffer_enable; // RULE_02 RULE_03
      wk_nxt[p] = pin_nxt[p];
      sx_nxt[p] = pin_nxt[p] & standby & ~wkup_restrict[p]; // RULE_10
    end
    for (int s = 0; s < SHARED_INS; s++)
      sh_nxt[s] = pin_nxt[sel_r[s*IW +: IW]]; // RULE_03
  end

  // Pad and peripheral registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pad_out <= '0;
      pad_oe <= '0; // RULE_04
      periph_in <= '0;
      shared_in <= '0;
      wakeup_in <= '0;
      ext_irq_in <= '0;
      standby_exit <= '0;
    end
    else if (clk_en)
    begin
      pad_out <= pout_nxt;
      pad_oe <= poe_nxt;
      periph_in <= pin_nxt;
      shared_in <= sh_nxt;
      wakeup_in <= wk_nxt; // RULE_09
      ext_irq_in <= wk_nxt; // RULE_09
      standby_exit <= sx_nxt;
    end
  end

endmodule

/* File: rtl/pfm_pkg.sv */
// Package: constants and types for the pad function multiplexer
// Functional notes
// RULE_01: Select code 00..11 picks alt function 0..3
// RULE_02: Input reaches peripherals only when buffer enabled
// RULE_03: Pad inputs fan out; select picks shared input
// RULE_04: Reset configuration holds until software changes it
// RULE_05: Interrupt override beats any alternate function
// RULE_06: Pads reset to GPIO except debug pads
// RULE_07: Data-out pad resets to alt two
// RULE_08: Data-out pad as GPIO drives output immediately
// RULE_09: Wakeup pads also feed external interrupts
// RULE_10: Restricted wakeup pads cannot exit standby
// RULE_11: Software keeps input buffer off where flagged
// RULE_12: Empty alternate slot leaves pad undriven
package pfm_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] PFM_CFG_BASE = 12'h0000;
  localparam logic [11:0] PFM_SEL_ADDR = 12'h0400;
  localparam logic [11:0] PFM_GPO_ADDR = 12'h0404;
  localparam logic [11:0] PFM_PIN_ADDR = 12'h0408;
  localparam logic [11:0] PFM_STBY_ADDR = 12'h040C;

  // ----------------------------------------
  // Config register field positions
  // ----------------------------------------
  localparam int PFM_ALT_LSB = 0;
  localparam int PFM_OBE_BIT = 2;
  localparam int PFM_IBE_BIT = 3;
  localparam int PFM_NMI_BIT = 4;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [4:0] PFM_RST_GPIO = 5'h00;
  // Debug data-out pad: alt two, output buffer enable set
  localparam logic [4:0] PFM_RST_TDO = 5'h06;
  // Debug input pads: alt two, input buffer on (pulled up)
  localparam logic [4:0] PFM_RST_DBGIN = 5'h0A;
  localparam int PFM_TDI_PAD = 0;
  localparam int PFM_TDO_PAD = 1;
  localparam int PFM_TCK_PAD = 2;
  localparam int PFM_TMS_PAD = 3;

  // Pad configuration word
  typedef struct packed {
    logic nmi_sel;
    logic input_buffer_enable;
    logic output_buffer_enable;
    logic [1:0] pad_alt_select;
  } pfm_cfg_t;

  // Decoded alternate function
  typedef enum logic [1:0] {
    PFM_ALT_ZERO,
    PFM_ALT_ONE,
    PFM_ALT_TWO,
    PFM_ALT_THREE
  } pfm_alt_t;

  // AXI4-Lite responses
  localparam logic [1:0] PFM_RESP_OKAY = 2'h0;
  localparam logic [1:0] PFM_RESP_SLVERR = 2'h2;

endpackage

/* File: rtl/pfm_cfg_mem.sv */
// Memory holding the per-pad configuration words
`timescale 1ns/1ps
module pfm_cfg_mem
  import pfm_pkg::*;
#(
  parameter int PADS = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Write port
  input wire logic wr_en,
  input wire logic [$clog2(PADS)-1:0] wr_idx,
  input wire logic [4:0] wr_data,
  // Read port, registered data
  input wire logic [$clog2(PADS)-1:0] rd_idx,
  output logic [4:0] rd_data,
  // Whole table for the muxing logic
  output pfm_cfg_t [PADS-1:0] cfg_all
);

  pfm_cfg_t [PADS-1:0] mem_r;
  pfm_cfg_t [PADS-1:0] mem_nxt;
  logic [4:0] rd_nxt;

  // Reset image: debug pads come up in their debug role
  function automatic logic [4:0] rst_word(input int i);
    if (i == PFM_TDO_PAD)
      return PFM_RST_TDO;
    if (i == PFM_TDI_PAD || i == PFM_TCK_PAD || i == PFM_TMS_PAD)
      return PFM_RST_DBGIN;
    return PFM_RST_GPIO;
  endfunction

  // Next table and read data
  always_comb
  begin
    mem_nxt = mem_r;
    if (wr_en)
      mem_nxt[wr_idx] = wr_data;
    rd_nxt = mem_r[rd_idx];
  end

  // Reset holds the documented configuration
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < PADS; i++)
        mem_r[i] <= rst_word(i); // RULE_04 RULE_06 RULE_07
      rd_data <= 5'h00;
    end
    else if (clk_en)
    begin
      mem_r <= mem_nxt;
      rd_data <= rd_nxt;
    end
  end

  assign cfg_all = mem_r;

endmodule

/* File: verification/pfm_top_checker.sv */
// Concurrent checks on the pad multiplexer top ports
`timescale 1ns/1ps
module pfm_top_checker #(
  parameter int PADS = 8
)
(
  // Clock and reset
  input logic clk,
  input logic sys_rst,
  // Bus handshakes
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [31:0] s_axi_rdata,
  // Pad and peripheral side
  input logic [PADS-1:0] pad_in,
  input logic [PADS-1:0] pad_oe,
  input logic [PADS-1:0] periph_in,
  input logic [PADS-1:0] wkup_restrict,
  input logic standby,
  input logic [PADS-1:0] wakeup_in,
  input logic [PADS-1:0] ext_irq_in,
  input logic [PADS-1:0] standby_exit
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Reset itself must leave pads undriven and inputs blocked
  a_reset_quiet: assert property (
    disable iff (1'b0) sys_rst |=> pad_oe == '0 && periph_in == '0)
    else $error("pad active right after reset");
  a_input_gated: assert property (
    (periph_in & ~$past(pad_in)) == '0)
    else $error("peripheral input without pad level");
  a_wkup_irq_same: assert property (
    wakeup_in == ext_irq_in)
    else $error("wakeup and interrupt copies differ");
  // Restricted pads never lead out of standby
  a_exit_restrict: assert property (
    (standby_exit & ($past(wkup_restrict) | ~wakeup_in)) == '0)
    else $error("standby exit from restricted pad");
  a_exit_standby: assert property (
    (|standby_exit) |-> $past(standby))
    else $error("standby exit outside standby");
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_r_latency: assert property (
    s_axi_arvalid && s_axi_arready |-> ##3 s_axi_rvalid)
    else $error("read answer late");
  a_w_latency: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[2:3] s_axi_bvalid)
    else $error("write answer late");
endmodule

/* File: verification/pfm_periph_model.sv */
// Peripheral side model: alternate drives, override drive, pad levels
`timescale 1ns/1ps
module pfm_periph_model #(
  parameter int PADS = 8
)
(
  // Clock and control
  input logic clk,
  input logic shuffle,
  // Toward the multiplexer
  output logic [PADS-1:0] alt_out [4],
  output logic [PADS-1:0] alt_oe [4],
  output logic [PADS-1:0] alt_present [4],
  output logic [PADS-1:0] nmi_out,
  output logic [PADS-1:0] nmi_oe,
  output logic [PADS-1:0] pad_in
);
  // Held in wide words; bits above the 64 random ones stay zero, so wide pad counts get zero tails
  logic [4*PADS-1:0] out_r = '0;
  logic [4*PADS-1:0] oe_r = '0;
  logic [4*PADS-1:0] pres_r = '0;
  logic [3*PADS-1:0] misc_r = '0;

  // New drive only on request, so expectations can settle
  always @(posedge clk)
  begin
    if (shuffle)
    begin
      out_r <= (4*PADS)'({$urandom, $urandom});
      oe_r <= (4*PADS)'({$urandom, $urandom});
      pres_r <= (4*PADS)'({$urandom, $urandom});
      misc_r <= (3*PADS)'({$urandom, $urandom});
    end
  end

  // Slot fan-out
  always_comb
  begin
    for (int s = 0; s < 4; s++)
    begin
      alt_out[s] = out_r[s*PADS +: PADS];
      alt_oe[s] = oe_r[s*PADS +: PADS];
      alt_present[s] = pres_r[s*PADS +: PADS];
    end
    {nmi_out, nmi_oe, pad_in} = misc_r;
  end
endmodule

/* File: verification/pfm_top_test.sv */
// Self-checking bench for the pad function multiplexer
`timescale 1ns/1ps
module pfm_top_test;
  import pfm_pkg::*;
  localparam int PADS = 8;
  localparam logic [63:0] WR_OK = {62'h0, PFM_RESP_OKAY};
  localparam logic [31:0] RD_OK = {30'h0, PFM_RESP_OKAY};
  // Pads whose input buffer software must leave off
  localparam logic [PADS-1:0] IBE_OFF = 8'h80;
  logic [PADS-1:0] sx_exp = '0;
  logic clk = 0, sys_rst = 1, shuffle = 0, chk = 0, standby = 0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, selr = '0, gpo = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, shared_in;
  logic [PADS-1:0] alt_out [4], alt_oe [4], alt_present [4];
  logic [PADS-1:0] nmi_out, nmi_oe, pad_in, pad_out, pad_oe, periph_in;
  logic [PADS-1:0] wkup_restrict = '0, wakeup_in, ext_irq_in, standby_exit;
  logic [4:0] cfg [PADS];
  logic [63:0] rq [$], bq [$], pq [$];
  int errors = 0, compares = 0;

  initial forever #10 clk = ~clk;

  pfm_top #(.PADS(PADS), .SHARED_INS(2)) pfm_top_inst (.clk, .sys_rst,
    .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .alt_out, .alt_oe, .alt_present,
    .nmi_out, .nmi_oe, .pad_in, .pad_out, .pad_oe, .periph_in, .shared_in,
    .wkup_restrict, .standby, .wakeup_in, .ext_irq_in, .standby_exit);
  pfm_periph_model #(.PADS(PADS)) pfm_periph_model_inst (.clk, .shuffle,
    .alt_out, .alt_oe, .alt_present, .nmi_out, .nmi_oe, .pad_in);

  // ----------------------------------------
  // Comparison and verdict
  // ----------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watcher: pops the oldest note whenever a result shows
  always @(posedge clk)
  begin
    if (s_axi_rvalid && s_axi_rready)
      check({30'h0, s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      check({62'h0, s_axi_bresp}, bq.pop_front());
    if (chk)
      check({22'h0, shared_in, wakeup_in, standby_exit, periph_in, pad_oe,
        pad_out & pad_oe}, pq.pop_front());
  end

  // One bus transfer; ready is raised late so the slave must hold
  task automatic xfer(input bit w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s, input logic [63:0] e);
    int n;
    n = 0;
    if (w)
    begin
      bq.push_back(e);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
    end
    else
    begin
      rq.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
    end
    while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 60)
    begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    if (n >= 60)
    begin
      errors++;
      tally_and_finish();
    end
    else
    begin
      if (w) s_axi_bready <= 1'b1;
      else s_axi_rready <= 1'b1;
      @(posedge clk);
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      @(posedge clk);
    end
  endtask

  // Expected pad picture from the shadow configuration
  task automatic snap();
    logic [PADS-1:0] o, e, p, x;
    logic [1:0] sh, s;
    repeat (4) @(posedge clk);
    for (int i = 0; i < PADS; i++)
    begin
      s = cfg[i][1:0];
      p[i] = pad_in[i] & cfg[i][3];
      if (cfg[i][4])
        {o[i], e[i]} = {nmi_out[i], nmi_oe[i]};
      else if (s == 2'b00)
        {o[i], e[i]} = {gpo[i], cfg[i][2]};
      else
        {o[i], e[i]} = {alt_out[s][i], alt_oe[s][i] & alt_present[s][i]};
    end
    for (int k = 0; k < 2; k++) sh[k] = p[selr[3*k +: 3]];
    x = p & {PADS{standby}} & ~wkup_restrict;
    sx_exp = x;
    pq.push_back({22'h0, sh, p, x, p, e, o & e});
    chk <= 1'b1;
    @(posedge clk);
    chk <= 1'b0;
    @(posedge clk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(70));
    shuffle <= 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    shuffle <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < PADS; i++) cfg[i] = PFM_RST_GPIO;
    cfg[PFM_TDI_PAD] = PFM_RST_DBGIN;
    cfg[PFM_TDO_PAD] = PFM_RST_TDO;
    cfg[PFM_TCK_PAD] = PFM_RST_DBGIN;
    cfg[PFM_TMS_PAD] = PFM_RST_DBGIN;
    for (int i = 0; i < PADS; i++)
      xfer(0, PFM_CFG_BASE + 12'(4*i), '0, '0, {RD_OK, 27'h0, cfg[i]});
    snap();
    // Data-out pad to GPIO keeps its enabled buffer
    cfg[PFM_TDO_PAD] = 5'h04;
    xfer(1, PFM_CFG_BASE + 12'h004, 32'h0000_0004, 4'h1, WR_OK);
    snap();
    // Disabled byte lane, then an unmapped place
    xfer(1, PFM_CFG_BASE + 12'h014, 32'h0000_001F, 4'h0, WR_OK);
    xfer(0, PFM_CFG_BASE + 12'h014, '0, '0, {RD_OK, 27'h0, cfg[5]});
    xfer(1, 12'h800, 32'h0000_0001, 4'hF, {62'h0, PFM_RESP_SLVERR});
    xfer(0, 12'h800, '0, '0, {30'h0, PFM_RESP_SLVERR, 32'h0});
    // Random sweep; select codes rotate so each pad sees all four
    for (int it = 0; it < 40; it++)
    begin
      shuffle <= 1'b1;
      standby <= 1'($urandom);
      wkup_restrict <= PADS'($urandom);
      @(posedge clk);
      shuffle <= 1'b0;
      selr = {26'h0, 6'($urandom)};
      gpo = 32'(PADS'($urandom));
      xfer(1, PFM_SEL_ADDR, selr, 4'hF, WR_OK);
      xfer(1, PFM_GPO_ADDR, gpo, 4'hF, WR_OK);
      xfer(0, PFM_SEL_ADDR, '0, '0, {RD_OK, selr});
      xfer(0, PFM_GPO_ADDR, '0, '0, {RD_OK, gpo});
      for (int i = 0; i < PADS; i++)
      begin
        cfg[i] = {3'($urandom), 2'(it + i)};
        if (IBE_OFF[i])
          cfg[i][PFM_IBE_BIT] = 1'b0;
        xfer(1, PFM_CFG_BASE + 12'(4*i), {27'h0, cfg[i]}, 4'h1, WR_OK);
      end
      xfer(0, PFM_PIN_ADDR, '0, '0, {RD_OK, 24'h0, pad_in});
      snap();
      xfer(0, PFM_STBY_ADDR, '0, '0, {RD_OK, 24'h0, sx_exp});
    end
    tally_and_finish();
  end
endmodule

bind pfm_top pfm_top_checker #(.PADS(PADS)) pfm_top_checker_inst (.clk,
  .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pad_in, .pad_oe, .periph_in,
  .wkup_restrict, .standby, .wakeup_in, .ext_irq_in, .standby_exit);
